// >>> hw/event_branch_flag_modify_exec.sv
// Purpose: Executes streamer event branches and the carry/zero truth-table modify group
// Assumes: One instruction presented per cycle with its own address and any prefix bits;
//          register operand already read and streamer flags on the core clock
// Notes:   Results are registered one cycle after the instruction is presented
// Operation
// - Opcode 1011110 with effects 01I and dest 000001011/000011011 jumps on finished set/clear.
// - Dest 000001010/000011010 jumps on the streamer-empty flag set/clear.
// - Dest 000001101/000011101 jumps on the lookup-RAM rollover flag set/clear.
// - Dest 000001100/000011100 jumps on the oscillator rollover flag set/clear.
// - The program counter is loaded only when the tested flag matches the encoded polarity.
// - With the immediate bit clear, the register value is an absolute 20-bit target.
// - With the immediate bit set and no prefix, the 9-bit source is a signed offset.
// - With a source prefix, the offset is a signed 20-bit value.
// - Relative targets are counted from the address of the following instruction.
// - The offset is added as-is in core/lookup execution and times four in shared memory.
// - Register operands give absolute targets and immediates give relative ones.
// - Carry modify decodes opcode 1101011, effects C01, modifier in dest 7:4, source 001101111.
// - Zero modify uses effects 0Z1 and dest 3:0, the combined form CZ1 with both fields.
// - Each new flag is the modifier bit indexed by the old carry and zero, carry high.
// - Carry changes only with its write effect, zero only with its own, and no register is written.
// - Modifier 0000 forces the flag to zero and 1111 forces it to one.
// - Modifier 1100 copies the old carry and 1010 copies the old zero.
`timescale 1ns/100ps

module event_branch_flag_modify_exec #(
  parameter int ADDR_W = evflag_pkg::ADDR_W
) (
  input  wire logic                       MCLK_I,
  input  wire logic                       RSTN_I,
  input  wire evflag_pkg::fetch_t         FETCH_I,
  input  wire logic [31:0]                SRC_REG_I,
  input  wire evflag_pkg::exec_mode_t     EXEC_MODE_I,
  input  wire evflag_pkg::stream_events_t EVENTS_I,
  output logic                            BRANCH_TAKEN_O,
  output logic [ADDR_W-1:0]               BRANCH_TARGET_O,
  output logic                            DONE_O,
  output logic                            CARRY_O,
  output logic                            ZERO_O
);

  function automatic logic truth_pick(input logic [3:0] table_bits, input logic c,
                                      input logic z);
    truth_pick = table_bits[{c, z}];
  endfunction

  logic [6:0]             opcode;
  logic [8:0]             dst_field;
  logic [8:0]             src_field;
  logic                   fx_c;
  logic                   fx_z;
  logic                   fx_i;
  logic                   is_event;
  logic                   is_modify;
  logic                   flag_sel;
  logic                   polarity_clear;
  logic                   dst_known;
  logic                   take;
  logic [ADDR_W-1:0]      offset;
  logic [ADDR_W-1:0]      scaled;
  logic [ADDR_W-1:0]      next_pc;
  logic [ADDR_W-1:0]      target;
  logic [3:0]             carry_truth_table;
  logic [3:0]             zero_truth_table;
  logic                   carry_nxt;
  logic                   zero_nxt;
  logic                   carry_r;
  logic                   zero_r;
  evflag_pkg::branch_t    br_nxt;
  evflag_pkg::branch_t    br_r;
  logic                   done_r;

  assign opcode    = FETCH_I.word[evflag_pkg::OPC_HI:evflag_pkg::OPC_LO];
  assign dst_field = FETCH_I.word[evflag_pkg::DST_HI:evflag_pkg::DST_LO];
  assign src_field = FETCH_I.word[evflag_pkg::SRC_HI:evflag_pkg::SRC_LO];
  assign fx_c      = FETCH_I.word[evflag_pkg::FX_C_BIT];
  assign fx_z      = FETCH_I.word[evflag_pkg::FX_Z_BIT];
  assign fx_i      = FETCH_I.word[evflag_pkg::FX_I_BIT];

  assign is_event  = FETCH_I.valid && (opcode == evflag_pkg::OPC_EVENT_BRANCH)
                     && ({fx_c, fx_z} == evflag_pkg::FX_EVENT_HI);
  assign is_modify = FETCH_I.valid && (opcode == evflag_pkg::OPC_FLAG_MODIFY) && fx_i
                     && (src_field == evflag_pkg::SRC_FLAG_MODIFY);

  always_comb
  begin
    flag_sel       = 1'b0;
    polarity_clear = 1'b0;
    dst_known      = 1'b1;
    case (dst_field)
      evflag_pkg::DST_STREAM_FINISHED:     flag_sel = EVENTS_I.finished;
      evflag_pkg::DST_STREAM_NOT_FINISHED:
      begin
        flag_sel       = EVENTS_I.finished;
        polarity_clear = 1'b1;
      end
      evflag_pkg::DST_STREAM_EMPTY:        flag_sel = EVENTS_I.empty;
      evflag_pkg::DST_STREAM_NOT_EMPTY:
      begin
        flag_sel       = EVENTS_I.empty;
        polarity_clear = 1'b1;
      end
      evflag_pkg::DST_LOOKUP_ROLLOVER:     flag_sel = EVENTS_I.lookup_rollover;
      evflag_pkg::DST_NO_LOOKUP_ROLLOVER:
      begin
        flag_sel       = EVENTS_I.lookup_rollover;
        polarity_clear = 1'b1;
      end
      evflag_pkg::DST_OSC_ROLLOVER:        flag_sel = EVENTS_I.osc_rollover;
      evflag_pkg::DST_NO_OSC_ROLLOVER:
      begin
        flag_sel       = EVENTS_I.osc_rollover;
        polarity_clear = 1'b1;
      end
      default:                             dst_known = 1'b0;
    endcase
  end

  assign take = is_event && dst_known && (flag_sel != polarity_clear);

  // Offset: 9-bit signed alone, or prefix bits over the low 9 for 20 bits
  assign offset = FETCH_I.aug_valid
                  ? ADDR_W'({FETCH_I.aug_bits[ADDR_W-evflag_pkg::AUG_SHIFT-1:0],
                             src_field})
                  : ADDR_W'({{(ADDR_W-evflag_pkg::FIELD_W){src_field[8]}}, src_field});

  assign scaled  = (EXEC_MODE_I == evflag_pkg::EXEC_SHARED_MEM)
                   ? ADDR_W'(offset << evflag_pkg::HUB_SHIFT)
                   : offset;
  assign next_pc = (EXEC_MODE_I == evflag_pkg::EXEC_SHARED_MEM)
                   ? ADDR_W'(FETCH_I.pc + ADDR_W'(1 << evflag_pkg::HUB_SHIFT))
                   : ADDR_W'(FETCH_I.pc + ADDR_W'(1));
  assign target  = fx_i ? ADDR_W'(next_pc + scaled)
                        : SRC_REG_I[ADDR_W-1:0];

  assign br_nxt.taken  = take;
  assign br_nxt.target = take ? target : br_r.target;

  assign carry_truth_table = dst_field[7:4];
  assign zero_truth_table  = dst_field[3:0];

  // Both use pre-instruction flags; table 0000/1111 force, 1100/1010 copy
  assign carry_nxt = (is_modify && fx_c)
                     ? truth_pick(carry_truth_table, carry_r, zero_r)
                     : carry_r;
  assign zero_nxt  = (is_modify && fx_z)
                     ? truth_pick(zero_truth_table, carry_r, zero_r)
                     : zero_r;

  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      br_r    <= '{taken: 1'b0, target: evflag_pkg::PC_RESET};
      carry_r <= evflag_pkg::C_RESET;
      zero_r  <= evflag_pkg::Z_RESET;
      done_r  <= 1'b0;
    end
    else
    begin
      br_r    <= br_nxt;
      carry_r <= carry_nxt;
      zero_r  <= zero_nxt;
      done_r  <= is_event || is_modify;
    end
  end

  assign BRANCH_TAKEN_O  = br_r.taken;
  assign BRANCH_TARGET_O = br_r.target;
  assign CARRY_O         = carry_r;
  assign ZERO_O          = zero_r;
  assign DONE_O          = done_r;

endmodule

// >>> shared/evflag_pkg.sv
// Purpose: Shared encodings and types for the event-branch and flag-modify executor
// Assumes: 32-bit instruction word laid out as cond/opcode/effects/dest/source
// Notes:   Field positions, opcode values and widths are named here only
package evflag_pkg;

  localparam int INSN_W    = 32;
  localparam int ADDR_W    = 20;
  localparam int FIELD_W   = 9;
  localparam int OPC_HI    = 27;
  localparam int OPC_LO    = 21;
  localparam int FX_C_BIT  = 20;
  localparam int FX_Z_BIT  = 19;
  localparam int FX_I_BIT  = 18;
  localparam int DST_HI    = 17;
  localparam int DST_LO    = 9;
  localparam int SRC_HI    = 8;
  localparam int SRC_LO    = 0;
  localparam int AUG_W     = 23;
  localparam int AUG_SHIFT = 9;
  localparam int HUB_SHIFT = 2;

  localparam logic [6:0] OPC_EVENT_BRANCH = 7'h5E;
  localparam logic [6:0] OPC_FLAG_MODIFY  = 7'h6B;
  localparam logic [1:0] FX_EVENT_HI      = 2'h1;
  localparam logic [8:0] SRC_FLAG_MODIFY  = 9'h06F;

  localparam logic [8:0] DST_STREAM_FINISHED     = 9'h00B;
  localparam logic [8:0] DST_STREAM_NOT_FINISHED = 9'h01B;
  localparam logic [8:0] DST_STREAM_EMPTY        = 9'h00A;
  localparam logic [8:0] DST_STREAM_NOT_EMPTY    = 9'h01A;
  localparam logic [8:0] DST_LOOKUP_ROLLOVER     = 9'h00D;
  localparam logic [8:0] DST_NO_LOOKUP_ROLLOVER  = 9'h01D;
  localparam logic [8:0] DST_OSC_ROLLOVER        = 9'h00C;
  localparam logic [8:0] DST_NO_OSC_ROLLOVER     = 9'h01C;

  localparam logic [ADDR_W-1:0] PC_RESET = 20'h00000;
  localparam logic              C_RESET  = 1'b0;
  localparam logic              Z_RESET  = 1'b0;

  typedef enum logic [1:0] {EXEC_CORE_REG, EXEC_LOOKUP_RAM, EXEC_SHARED_MEM} exec_mode_t;

  typedef struct packed {
    logic finished;
    logic empty;
    logic lookup_rollover;
    logic osc_rollover;
  } stream_events_t;

  typedef struct packed {
    logic              valid;
    logic [INSN_W-1:0] word;
    logic [ADDR_W-1:0] pc;
    logic              aug_valid;
    logic [AUG_W-1:0]  aug_bits;
  } fetch_t;

  typedef struct packed {
    logic              taken;
    logic [ADDR_W-1:0] target;
  } branch_t;

endpackage

// >>> verification/exec_props.sv
// Purpose: Port properties of the executor
// Assumes: One clock, async active-low reset
// Notes:   Bound to the top module
`timescale 1ns/100ps
module exec_props #(parameter int ADDR_W = evflag_pkg::ADDR_W) (
  input wire logic                       MCLK_I,
  input wire logic                       RSTN_I,
  input wire evflag_pkg::fetch_t         FETCH_I,
  input wire logic [31:0]                SRC_REG_I,
  input wire evflag_pkg::exec_mode_t     EXEC_MODE_I,
  input wire evflag_pkg::stream_events_t EVENTS_I,
  input wire logic                       BRANCH_TAKEN_O,
  input wire logic [ADDR_W-1:0]          BRANCH_TARGET_O,
  input wire logic                       DONE_O,
  input wire logic                       CARRY_O,
  input wire logic                       ZERO_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  wire logic [31:0] w = FETCH_I.word;
  wire logic [8:0]  d = w[17:9];
  wire logic [3:0]  ev = EVENTS_I;
  wire logic        ev_ok = FETCH_I.valid && w[27:21] == evflag_pkg::OPC_EVENT_BRANCH
    && w[20:19] == 2'h1 && d[8:5] == 4'h0 && d[3] && (d[2] ^ d[1]);
  wire logic        fl = d[3:0] == 4'hB ? ev[3] : d[3:0] == 4'hA ? ev[2] :
    d[3:0] == 4'hD ? ev[1] : ev[0];
  wire logic        take = ev_ok && (fl ^ d[4]);
  wire logic        sh = EXEC_MODE_I == evflag_pkg::EXEC_SHARED_MEM;
  wire logic [19:0] off = FETCH_I.aug_valid ? {FETCH_I.aug_bits[10:0], w[8:0]} : {{11{w[8]}}, w[8:0]};
  wire logic [19:0] rel = FETCH_I.pc + (sh ? 20'h4 + (off << 2) : 20'h1 + off);
  wire logic        mod_ok = FETCH_I.valid && w[27:21] == evflag_pkg::OPC_FLAG_MODIFY && w[18]
    && w[8:0] == evflag_pkg::SRC_FLAG_MODIFY;
  wire logic [1:0]  ix = {CARRY_O, ZERO_O};
  wire logic [3:0]  cm = w[16:13];
  wire logic [3:0]  zm = w[12:9];
  a_insn_done: assert property ((ev_ok || mod_ok) |=> DONE_O) else $error("done missing");
  a_done_cause: assert property (DONE_O |-> $past(ev_ok || mod_ok)) else $error("stray done");
  a_branch_taken: assert property (take |=> BRANCH_TAKEN_O) else $error("no branch");
  a_branch_skip: assert property (!take |=> !BRANCH_TAKEN_O) else $error("bad branch");
  a_target_hold: assert property (!BRANCH_TAKEN_O |-> $stable(BRANCH_TARGET_O)) else $error("pc");
  a_abs_target: assert property (take && !w[18] |=> BRANCH_TARGET_O == $past(SRC_REG_I[19:0]))
    else $error("abs target");
  a_rel_target: assert property (take && w[18] |=> BRANCH_TARGET_O == $past(rel))
    else $error("rel target");
  a_carry_new: assert property (mod_ok && w[20] |=> CARRY_O == $past(cm[ix])) else $error("c");
  a_zero_new: assert property (mod_ok && w[19] |=> ZERO_O == $past(zm[ix])) else $error("z");
  a_carry_kept: assert property (!(mod_ok && w[20]) |=> $stable(CARRY_O)) else $error("c kept");
  a_zero_kept: assert property (!(mod_ok && w[19]) |=> $stable(ZERO_O)) else $error("z kept");
endmodule
bind event_branch_flag_modify_exec exec_props #(.ADDR_W(ADDR_W)) props_u (.MCLK_I(MCLK_I),
  .RSTN_I(RSTN_I), .FETCH_I(FETCH_I), .SRC_REG_I(SRC_REG_I), .EXEC_MODE_I(EXEC_MODE_I),
  .EVENTS_I(EVENTS_I), .BRANCH_TAKEN_O(BRANCH_TAKEN_O), .BRANCH_TARGET_O(BRANCH_TARGET_O),
  .DONE_O(DONE_O), .CARRY_O(CARRY_O), .ZERO_O(ZERO_O));

// >>> verification/fetch_events_model.sv
// Purpose: Core fetch and streamer flag source
// Assumes: Issues one instruction at a time
// Notes:   Word is inverted while no instruction is valid
`timescale 1ns/100ps
module fetch_events_model (
  input  wire logic                   clk_i,
  output evflag_pkg::fetch_t          fetch_o,
  output logic [31:0]                 src_o,
  output evflag_pkg::exec_mode_t      mode_o,
  output evflag_pkg::stream_events_t  ev_o
);
  initial
  begin
    fetch_o = '0;
    src_o = '0;
    mode_o = evflag_pkg::EXEC_CORE_REG;
    ev_o = '0;
  end
  task automatic issue(input logic [31:0] w, input logic [19:0] pc, input logic av,
    input logic [22:0] ab, input logic [31:0] s, input evflag_pkg::exec_mode_t m,
    input logic [3:0] e);
    @(posedge clk_i);
    fetch_o <= '{1'b1, w, pc, av, ab};
    src_o <= s;
    mode_o <= m;
    ev_o <= e;
    @(posedge clk_i);
    fetch_o.valid <= 1'b0;
    fetch_o.word <= ~w;
  endtask
endmodule

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the executor
// Assumes: Fetch model drives all inputs except clock and reset, which the bench drives
// Notes:   Expected flags tracked in c_r and z_r
`timescale 1ns/100ps
module testbench;
  logic                       MCLK_I = 1'b0;
  logic                       RSTN_I = 1'b0;
  evflag_pkg::fetch_t         FETCH_I;
  logic [31:0]                SRC_REG_I;
  evflag_pkg::exec_mode_t     EXEC_MODE_I;
  evflag_pkg::stream_events_t EVENTS_I;
  logic                       BRANCH_TAKEN_O, DONE_O, CARRY_O, ZERO_O;
  logic [19:0]                BRANCH_TARGET_O;
  int                         bad_count = 0;
  int                         comparisons = 0;
  logic                       c_r = 1'b0;
  logic                       z_r = 1'b0;
  always #25 MCLK_I = ~MCLK_I;
  fetch_events_model pm_u (.clk_i(MCLK_I), .fetch_o(FETCH_I), .src_o(SRC_REG_I),
    .mode_o(EXEC_MODE_I), .ev_o(EVENTS_I));
  event_branch_flag_modify_exec dut_u (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .FETCH_I(FETCH_I),
    .SRC_REG_I(SRC_REG_I), .EXEC_MODE_I(EXEC_MODE_I), .EVENTS_I(EVENTS_I),
    .BRANCH_TAKEN_O(BRANCH_TAKEN_O), .BRANCH_TARGET_O(BRANCH_TARGET_O), .DONE_O(DONE_O),
    .CARRY_O(CARRY_O), .ZERO_O(ZERO_O));
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [31:0] ebr(input logic [2:0] fx, input logic [8:0] d, input logic [8:0] s);
    return {4'hF, evflag_pkg::OPC_EVENT_BRANCH, fx, d, s};
  endfunction
  task automatic run_br(input logic [31:0] w, input logic [19:0] pc, input logic av,
    input logic [22:0] ab, input logic [31:0] s, input evflag_pkg::exec_mode_t m,
    input logic [3:0] e, input logic tk, input logic [19:0] t);
    pm_u.issue(w, pc, av, ab, s, m, e);
    #1;
    chk("branch done taken", {1'b1, tk}, {DONE_O, BRANCH_TAKEN_O});
    if (tk)
      chk("target", t, BRANCH_TARGET_O);
    @(posedge MCLK_I);
    #1;
    chk("pulse end", 24'h0, {DONE_O, BRANCH_TAKEN_O});
  endtask
  task automatic t_events;
    logic [3:0] lo [4] = '{4'hB, 4'hA, 4'hD, 4'hC};
    for (int i = 0; i < 16; i++)
      run_br(ebr(3'b011, {4'h0, i[3], lo[i%4]}, 9'h100), 20'h00400, 1'b0, 23'h0, 32'h0,
        evflag_pkg::EXEC_CORE_REG, i[2] ? 4'h8 >> (i % 4) : 4'h0, i[2] ^ i[3], 20'h00301);
  endtask
  task automatic t_targets;
    run_br(ebr(3'b010, 9'h00B, 9'h000), 20'h00400, 1'b0, 23'h0, 32'hABC12345,
      evflag_pkg::EXEC_SHARED_MEM, 4'h8, 1'b1, 20'h12345);
    run_br(ebr(3'b011, 9'h00B, 9'h0FF), 20'h01000, 1'b0, 23'h0, 32'h0,
      evflag_pkg::EXEC_SHARED_MEM, 4'h8, 1'b1, 20'h01400);
    run_br(ebr(3'b011, 9'h01B, 9'h1FF), 20'h00010, 1'b1, 23'h0003FF, 32'h0,
      evflag_pkg::EXEC_LOOKUP_RAM, 4'h0, 1'b1, 20'h80010);
    pm_u.issue(ebr(3'b111, 9'h00B, 9'h000), 20'h0, 1'b0, 23'h0, 32'h0, evflag_pkg::EXEC_CORE_REG, 4'h8);
    #1;
    chk("refused", 24'h0, {DONE_O, BRANCH_TAKEN_O});
  endtask
  task automatic run_mod(input logic [2:0] fx, input logic [3:0] cm, input logic [3:0] zm);
    logic [1:0] ix;
    ix = {c_r, z_r};
    pm_u.issue({4'hF, evflag_pkg::OPC_FLAG_MODIFY, fx, 1'b0, cm, zm, evflag_pkg::SRC_FLAG_MODIFY},
      20'h0, 1'b0, 23'h0, 32'h0, evflag_pkg::EXEC_CORE_REG, 4'h0);
    c_r = fx[2] ? cm[ix] : c_r;
    z_r = fx[1] ? zm[ix] : z_r;
    #1;
    chk("done c z", {1'b1, c_r, z_r}, {DONE_O, CARRY_O, ZERO_O});
  endtask
  initial
  begin
    #100000;
    bad_count++;
    final_report();
  end
  initial
  begin
    @(posedge MCLK_I);
    #1;
    chk("reset outputs", 24'h0, {BRANCH_TAKEN_O, CARRY_O, ZERO_O, DONE_O, BRANCH_TARGET_O});
    @(posedge MCLK_I);
    @(posedge MCLK_I);
    RSTN_I <= 1'b1;
    t_events();
    t_targets();
    run_mod(3'b111, 4'hF, 4'hF);
    run_mod(3'b101, 4'hA, 4'h0);
    run_mod(3'b011, 4'h0, 4'h0);
    run_mod(3'b011, 4'h0, 4'hC);
    run_mod(3'b001, 4'h0, 4'h0);
    run_mod(3'b111, 4'h0, 4'hC);
    run_mod(3'b111, 4'hA, 4'hF);
    final_report();
  end
endmodule
